/* rtl/res_defs.svh */
// Offsets, field positions, reset values and timing counts of the
// rail enable sequencer. Included by every design file that needs them.
`ifndef RES_DEFS_SVH
`define RES_DEFS_SVH

`define RES_NRAIL 13
`define RES_NBUCK 6
`define RES_NSLP 9
`define RES_AW 8

// Rail indices
`define RES_BUCK_A 0
`define RES_BUCK_B 1
`define RES_BUCK_C 2
`define RES_BUCK_D 3
`define RES_BUCK_E 4
`define RES_BUCK_F 5
`define RES_LIN_A 6
`define RES_LIN_B 7
`define RES_LIN_C 8
`define RES_TERM 9
`define RES_SW_A 10
`define RES_SW_B1 11
`define RES_SW_B2 12

// Register byte offsets
`define RES_A_CTRL 8'h00
`define RES_A_SLEEP 8'h04
`define RES_A_PWM 8'h08
`define RES_A_FMASK 8'h0C
`define RES_A_STATUS 8'h10
`define RES_A_FAULT 8'h14
`define RES_A_VIDF 8'h18
`define RES_A_VIDF_SLP 8'h1C

// Control and status register fields
`define RES_CTRL_LIN_A 0
`define RES_CTRL_LIN_B 1
`define RES_CTRL_LIN_C 2
`define RES_CTRL_GPO_C 3
`define RES_CTRL_GPO_D 4
`define RES_STAT_SHUT 16

// Reset values
`define RES_CTRL_RST 5'h00
`define RES_SLEEP_RST 9'h020
`define RES_PWM_RST 6'h00
`define RES_FMASK_RST 13'h1DC0
`define RES_VIDF_RST 7'h2C
`define RES_VIDF_SLP_RST 7'h26
`define RES_STEP_FINE 6'h01

// Timing: off delay of each sequenced buck
`define RES_OFF_DLY_MS 4
`define RES_CLK_KHZ 125000
`define RES_OFF_DLY_CYC (`RES_OFF_DLY_MS * `RES_CLK_KHZ)

`endif

/* rtl/res_pkg.sv */
// Types shared by the rail enable sequencer modules.
// Assumes res_defs.svh supplies the numeric constants.
package res_pkg;

  typedef enum logic [2:0] {
    RES_DLY_OFF = 3'b001,
    RES_DLY_ON = 3'b010,
    RES_DLY_DRAIN = 3'b100
  } res_dly_e;

endpackage

/* rtl/res_off_delay.sv */
// One rail enable with immediate turn-on and delayed turn-off.
// Assumes want is synchronous to clk; kill drops the rail at once.
`timescale 1ns/1ps
`include "res_defs.svh"

module res_off_delay
  import res_pkg::*;
#(
  parameter int DLY_CYC = `RES_OFF_DLY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic want,
  input wire logic kill,
  output logic en
);

  localparam int CW = (DLY_CYC > 1) ? $clog2(DLY_CYC) : 1;

  if (DLY_CYC < 1) begin : g_bad_dly
    $error("res_off_delay: DLY_CYC must be at least 1");
  end

  typedef struct packed {
    res_dly_e st;
    logic [CW-1:0] cnt;
  } res_dly_s;

  res_dly_s cur;
  res_dly_s next_cur;

  always_comb begin
    next_cur = cur;
    case (cur.st)
      RES_DLY_OFF: begin
        if (want && !kill) begin
          next_cur.st = RES_DLY_ON;
        end
      end
      RES_DLY_ON: begin
        if (kill) begin
          next_cur.st = RES_DLY_OFF;
        end else if (!want) begin
          next_cur.st = RES_DLY_DRAIN;
          next_cur.cnt = '0;
        end
      end
      RES_DLY_DRAIN: begin
        if (kill) begin
          next_cur.st = RES_DLY_OFF;
        end else if (want) begin
          next_cur.st = RES_DLY_ON;
        end else if (cur.cnt == CW'(DLY_CYC - 1)) begin
          next_cur.st = RES_DLY_OFF;
        end else begin
          next_cur.cnt = cur.cnt + 1'b1;
        end
      end
      default: begin
        next_cur.st = RES_DLY_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur.st <= RES_DLY_OFF;
      cur.cnt <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign en = (cur.st != RES_DLY_OFF);

endmodule

/* rtl/res_apb_slave.sv */
// APB slave front end: one wait state, then pready with read data.
// Assumes the top decodes the address into rd_data and hit.
`timescale 1ns/1ps
`include "res_defs.svh"

module res_apb_slave
  import res_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] rd_data,
  input wire logic hit,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wr_en
);

  typedef struct packed {
    logic rdy;
    logic err;
    logic [31:0] rdat;
  } res_apb_s;

  res_apb_s cur;
  res_apb_s next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.rdy = 1'b0;
    next_cur.err = 1'b0;
    // One wait state keeps the read mux off the pready path
    if (psel && penable && !cur.rdy) begin
      next_cur.rdy = 1'b1;
      next_cur.err = !hit;
      next_cur.rdat = (!pwrite && hit) ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur.rdy <= 1'b0;
      cur.err <= 1'b0;
      cur.rdat <= 32'h00000000;
    end else begin
      cur <= next_cur;
    end
  end

  assign pready = cur.rdy;
  assign pslverr = cur.err;
  assign prdata = cur.rdat;
  assign wr_en = psel && penable && pwrite && cur.rdy && !cur.err;

endmodule

/* rtl/res_top.sv */
// Rail enable sequencer: pin, power-good and register driven rail
// enables, sleep voltage selection, fault masking and open-drain outputs.
// Assumes all pins are synchronous to clk and rail_pg/rail_fault come
// from the analog rails. Registers are reached over APB.
//
// Summary of operation
// - Bucks, term rail, switches and general outputs a and b follow control pins and other rails' power-good.
// - Both main inputs dropping together run both power-down sequences at once.
// - First main input dropping first pulls general outputs a and b low.
// - A buck losing its upstream power-good is disabled.
// - Each lost buck turns off after 4 ms, cascading down the chain.
// - Fourth control input enables load switch a and first b switch.
// - Fifth control input enables the second b switch independently.
// - Linear rails b and c are switched only by register writes.
// - Linear rail a stays out of sequence; shared registers act on it.
// - B switches are unmerged; shared registers act on the second switch.
// - Buck a uses the fine step, default equals sleep, sleep disabled.
// - Buck f has sleep enabled, 1.5 V default, 1.35 V sleep code.
// - General outputs c and d are open-drain, register driven, default low.
// - Linear rails b and c: sleep disabled, faults masked by default.
// - Sixth control input picks sleep or normal code for sleep-enabled rails.
// - Without forced PWM each buck runs in automatic PWM/PFM mode.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "res_defs.svh"

module res_top
  import res_pkg::*;
#(
  parameter int OFF_DLY_CYC = `RES_OFF_DLY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RES_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_seq_in_a,
  input wire logic main_seq_in_b,
  input wire logic term_ldo_enable_in,
  input wire logic switch_group1_enable_in,
  input wire logic switch_group2_enable_in,
  input wire logic sleep_select_in,
  input wire logic [`RES_NRAIL-1:0] rail_pg,
  input wire logic [`RES_NRAIL-1:0] rail_fault,
  output logic [`RES_NRAIL-1:0] rail_en,
  output logic [`RES_NBUCK-1:0] step_down_pwm_force,
  output logic [`RES_NSLP-1:0] sleep_active,
  output logic [`RES_NBUCK-1:0] step_fine,
  output logic [6:0] rail_f_voltage_code,
  output logic fault_shutdown,
  output logic gen_out_a_o,
  output logic gen_out_a_oe,
  output logic gen_out_b_o,
  output logic gen_out_b_oe,
  output logic gen_out_c_o,
  output logic gen_out_c_oe,
  output logic gen_out_d_o,
  output logic gen_out_d_oe
);

  if (OFF_DLY_CYC < 1) begin : g_bad_dly
    $error("res_top: OFF_DLY_CYC must be at least 1");
  end

  typedef struct packed {
    logic [4:0] ctrl;
    logic [`RES_NSLP-1:0] sleep_en;
    logic [`RES_NBUCK-1:0] pwm;
    logic [`RES_NRAIL-1:0] fmask;
    logic [`RES_NRAIL-1:0] fsticky;
    logic shut;
    logic [6:0] vid_norm;
    logic [6:0] vid_slp;
    logic [6:0] vid_out;
    logic [`RES_NRAIL-1:0] en;
    logic [`RES_NSLP-1:0] slp_act;
    logic [3:0] od_low;
    // Fixed values still leave a flop so every output is registered
    logic [`RES_NBUCK-1:0] fine;
    logic [3:0] pin_o;
  } res_top_s;

  res_top_s cur;
  res_top_s next_cur;

  logic [31:0] rd_data;
  logic hit;
  logic wr_en;
  logic [`RES_NBUCK-1:0] buck_want;
  logic [`RES_NBUCK-1:0] buck_on;
  logic [`RES_NRAIL-1:0] unmasked;

  res_apb_slave u_apb (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .rd_data(rd_data),
    .hit(hit),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wr_en(wr_en)
  );

  // Buck chain: bucks b to e each need the previous stage's power-good and buck f
  // needs buck a's, so a lost enable ripples down one 4 ms delay per stage.
  always_comb begin
    buck_want[`RES_BUCK_A] = main_seq_in_a;
    buck_want[`RES_BUCK_B] = main_seq_in_b && rail_pg[`RES_BUCK_A];
    buck_want[`RES_BUCK_C] = rail_pg[`RES_BUCK_B];
    buck_want[`RES_BUCK_D] = rail_pg[`RES_BUCK_C];
    buck_want[`RES_BUCK_E] = rail_pg[`RES_BUCK_D];
    buck_want[`RES_BUCK_F] = main_seq_in_b && rail_pg[`RES_BUCK_A];
  end

  // Both inputs low together drop the wants of bucks a, b and f in one cycle,
  // so both sequences start on the same edge
  genvar gi;
  generate
    for (gi = 0; gi < `RES_NBUCK; gi++) begin : g_buck
      res_off_delay #(
        .DLY_CYC(OFF_DLY_CYC)
      ) u_dly (
        .clk(clk),
        .rst(rst),
        .want(buck_want[gi]),
        .kill(cur.shut),
        .en(buck_on[gi])
      );
    end
  endgenerate

  assign unmasked = rail_fault & ~cur.fmask;

  // Address decode for reads
  always_comb begin
    rd_data = 32'h00000000;
    hit = 1'b1;
    if (paddr == `RES_A_CTRL) begin
      rd_data[4:0] = cur.ctrl;
    end else if (paddr == `RES_A_SLEEP) begin
      rd_data[`RES_NSLP-1:0] = cur.sleep_en;
    end else if (paddr == `RES_A_PWM) begin
      rd_data[`RES_NBUCK-1:0] = cur.pwm;
    end else if (paddr == `RES_A_FMASK) begin
      rd_data[`RES_NRAIL-1:0] = cur.fmask;
    end else if (paddr == `RES_A_STATUS) begin
      rd_data[`RES_NRAIL-1:0] = cur.en;
      rd_data[`RES_STAT_SHUT] = cur.shut;
    end else if (paddr == `RES_A_FAULT) begin
      rd_data[`RES_NRAIL-1:0] = cur.fsticky;
    end else if (paddr == `RES_A_VIDF) begin
      rd_data[6:0] = cur.vid_norm;
    end else if (paddr == `RES_A_VIDF_SLP) begin
      rd_data[6:0] = cur.vid_slp;
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    next_cur = cur;
    if (wr_en) begin
      if (paddr == `RES_A_CTRL) begin
        next_cur.ctrl = pwdata[4:0];
      end else if (paddr == `RES_A_SLEEP) begin
        next_cur.sleep_en = pwdata[`RES_NSLP-1:0];
      end else if (paddr == `RES_A_PWM) begin
        next_cur.pwm = pwdata[`RES_NBUCK-1:0];
      end else if (paddr == `RES_A_FMASK) begin
        next_cur.fmask = pwdata[`RES_NRAIL-1:0];
      end else if (paddr == `RES_A_FAULT) begin
        next_cur.fsticky = cur.fsticky & ~pwdata[`RES_NRAIL-1:0];
      end else if (paddr == `RES_A_VIDF) begin
        next_cur.vid_norm = pwdata[6:0];
      end else if (paddr == `RES_A_VIDF_SLP) begin
        next_cur.vid_slp = pwdata[6:0];
      end
    end
    // A fault in the clearing cycle survives the clear
    next_cur.fsticky = next_cur.fsticky | rail_fault;
    // Shutdown holds until every unmasked sticky fault is cleared
    next_cur.shut = |(next_cur.fsticky & ~next_cur.fmask) | (|unmasked);

    next_cur.en[`RES_NBUCK-1:0] = buck_on & {`RES_NBUCK{!cur.shut}};
    next_cur.en[`RES_LIN_A] = cur.ctrl[`RES_CTRL_LIN_A] && !cur.shut;
    next_cur.en[`RES_LIN_B] = cur.ctrl[`RES_CTRL_LIN_B] && !cur.shut;
    next_cur.en[`RES_LIN_C] = cur.ctrl[`RES_CTRL_LIN_C] && !cur.shut;
    next_cur.en[`RES_TERM] = term_ldo_enable_in && !cur.shut;
    next_cur.en[`RES_SW_A] = switch_group1_enable_in && !cur.shut;
    next_cur.en[`RES_SW_B1] = switch_group1_enable_in && !cur.shut;
    next_cur.en[`RES_SW_B2] = switch_group2_enable_in && !cur.shut;

    next_cur.slp_act = cur.sleep_en & {`RES_NSLP{sleep_select_in}};
    next_cur.vid_out = (cur.sleep_en[`RES_BUCK_F] && sleep_select_in) ?
                       cur.vid_slp : cur.vid_norm;

    // Open-drain: pulling low means driving; released means high
    next_cur.od_low[0] = !(main_seq_in_a && !cur.shut &&
                           rail_pg[`RES_BUCK_A] &&
                           rail_pg[`RES_BUCK_B]);
    next_cur.od_low[1] = !(main_seq_in_a && main_seq_in_b && !cur.shut &&
                           rail_pg[`RES_BUCK_C] &&
                           rail_pg[`RES_BUCK_D] &&
                           rail_pg[`RES_BUCK_E]);
    next_cur.od_low[2] = !cur.ctrl[`RES_CTRL_GPO_C];
    next_cur.od_low[3] = !cur.ctrl[`RES_CTRL_GPO_D];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur.ctrl <= `RES_CTRL_RST;
      cur.sleep_en <= `RES_SLEEP_RST;
      cur.pwm <= `RES_PWM_RST;
      cur.fmask <= `RES_FMASK_RST;
      cur.fsticky <= '0;
      cur.shut <= 1'b0;
      cur.vid_norm <= `RES_VIDF_RST;
      cur.vid_slp <= `RES_VIDF_SLP_RST;
      cur.vid_out <= `RES_VIDF_RST;
      cur.en <= '0;
      cur.slp_act <= '0;
      cur.od_low <= 4'hF;
      cur.fine <= `RES_STEP_FINE;
      cur.pin_o <= 4'h0;
    end else begin
      cur <= next_cur;
    end
  end

  assign rail_en = cur.en;
  assign step_down_pwm_force = cur.pwm;
  assign sleep_active = cur.slp_act;
  assign step_fine = cur.fine;
  assign rail_f_voltage_code = cur.vid_out;
  assign fault_shutdown = cur.shut;
  // Open-drain pins only ever pull low
  assign gen_out_a_o = cur.pin_o[0];
  assign gen_out_b_o = cur.pin_o[1];
  assign gen_out_c_o = cur.pin_o[2];
  assign gen_out_d_o = cur.pin_o[3];
  assign gen_out_a_oe = cur.od_low[0];
  assign gen_out_b_oe = cur.od_low[1];
  assign gen_out_c_oe = cur.od_low[2];
  assign gen_out_d_oe = cur.od_low[3];

endmodule

/* tb/res_chk.sv */
// Port-level assertions for the rail enable sequencer.
// Assumes a bind to res_top with the same off-delay count.
`timescale 1ns/1ps
`include "res_defs.svh"
module res_chk #(
  parameter int OFF_DLY_CYC = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic main_seq_in_a,
  input wire logic main_seq_in_b,
  input wire logic term_ldo_enable_in,
  input wire logic switch_group2_enable_in,
  input wire logic sleep_select_in,
  input wire logic [`RES_NRAIL-1:0] rail_pg,
  input wire logic [`RES_NRAIL-1:0] rail_en,
  input wire logic [`RES_NSLP-1:0] sleep_active,
  input wire logic [`RES_NBUCK-1:0] step_fine,
  input wire logic fault_shutdown,
  input wire logic gen_out_a_oe,
  input wire logic gen_out_b_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since buck b lost its want (main_seq_in_b and buck a power-good); saturates so it never wraps
  logic [15:0] lost;
  always_ff @(posedge clk) begin
    if (rst || (main_seq_in_b && rail_pg[0]))
      lost <= 16'h0000;
    else if (lost != 16'hFFFF)
      lost <= lost + 16'h0001;
  end
  AST_PREADY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_SLVERR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_GPO_DROP: assert property (!main_seq_in_a |=> gen_out_a_oe && gen_out_b_oe)
    else $error("outputs a b not low");
  AST_SLEEP_GATE: assert property (!sleep_select_in |=> sleep_active == '0)
    else $error("sleep without select");
  AST_STEP: assert property (step_fine == 6'h01)
    else $error("step size wrong");
  AST_SHUT: assert property (fault_shutdown && $past(fault_shutdown) |-> rail_en == '0)
    else $error("rail on in shutdown");
  AST_SW_B2: assert property ($rose(switch_group2_enable_in) && !fault_shutdown |-> ##[1:3] rail_en[12])
    else $error("switch b2 not on");
  AST_TERM: assert property ($rose(term_ldo_enable_in) && !fault_shutdown |-> ##[1:3] rail_en[9])
    else $error("term rail not on");
  AST_CASCADE: assert property (lost > OFF_DLY_CYC + 4 |-> !rail_en[1])
    else $error("buck b still on");
  cover property (pslverr);
  cover property ($fell(rail_en[1]));
  cover property (fault_shutdown);
endmodule
bind res_top res_chk #(.OFF_DLY_CYC(OFF_DLY_CYC)) CHK (.clk, .rst, .psel,
  .penable, .pready, .pslverr, .main_seq_in_a, .main_seq_in_b,
  .term_ldo_enable_in, .switch_group2_enable_in, .sleep_select_in,
  .rail_pg, .rail_en, .sleep_active, .step_fine, .fault_shutdown,
  .gen_out_a_oe, .gen_out_b_oe);

/* tb/res_rails.sv */
// Stand-in for the analog rails: power-good follows each enable.
// Assumes slow adds one ramp cycle; good drops at once on disable.
`timescale 1ns/1ps
`include "res_defs.svh"
module res_rails (
  input wire logic clk,
  input wire logic slow,
  input wire logic [`RES_NRAIL-1:0] en,
  output logic [`RES_NRAIL-1:0] pg
);
  logic [`RES_NRAIL-1:0] ramp;
  always_ff @(posedge clk) begin
    ramp <= en;
    pg <= en & (slow ? ramp : en);
  end
endmodule

/* tb/test_rail_enable_sequencer.sv */
// Self-checking bench for res_top with an APB master and rail model.
// Assumes a short off delay of 8 cycles for the run.
`timescale 1ns/1ps
`include "res_defs.svh"
module test_rail_enable_sequencer;
  typedef struct {
    logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;
  } res_row_s;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, e, fault_shutdown;
  logic main_seq_in_a = 0, main_seq_in_b = 0, term_ldo_enable_in = 0;
  logic switch_group1_enable_in = 0, switch_group2_enable_in = 0;
  logic sleep_select_in = 0;
  logic [12:0] rail_pg, rail_fault = 0, rail_en;
  logic [5:0] step_down_pwm_force, step_fine;
  logic [8:0] sleep_active;
  logic [6:0] rail_f_voltage_code;
  logic gen_out_a_o, gen_out_a_oe, gen_out_b_o, gen_out_b_oe;
  logic gen_out_c_o, gen_out_c_oe, gen_out_d_o, gen_out_d_oe;
  int failures = 0, check_count = 0, cyc = 0, t0, t1;
  res_row_s rows[13] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h20, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 32'h1DC0, 1'b0},
    '{1'b0, 8'h18, 32'h0, 32'h2C, 1'b0},
    '{1'b0, 8'h1C, 32'h0, 32'h26, 1'b0},
    '{1'b1, 8'h08, 32'h15, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h15, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h14, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h18, 32'h2D, 32'h0, 1'b0},
    '{1'b0, 8'h18, 32'h0, 32'h2D, 1'b0},
    '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1}};
  res_top #(.OFF_DLY_CYC(8)) DUT (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .main_seq_in_a,
    .main_seq_in_b, .term_ldo_enable_in, .switch_group1_enable_in,
    .switch_group2_enable_in, .sleep_select_in, .rail_pg, .rail_fault,
    .rail_en, .step_down_pwm_force, .sleep_active, .step_fine,
    .rail_f_voltage_code, .fault_shutdown, .gen_out_a_o, .gen_out_a_oe,
    .gen_out_b_o, .gen_out_b_oe, .gen_out_c_o, .gen_out_c_oe,
    .gen_out_d_o, .gen_out_d_oe);
  res_rails PM (.clk(clk), .slow(slow), .en(rail_en), .pg(rail_pg));
  always #4 clk = ~clk;
  task finish_test;
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Holds the request until pready is sampled high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task wfall(input int i, output int n);
    n = 0;
    while (rail_en[i] !== 1'b0 && n < 500) begin
      @(posedge clk);
      n++;
    end
  endtask
  task seq(input logic a, input logic b, input int n);
    main_seq_in_a <= a; main_seq_in_b <= b;
    tick(n);
  endtask
  initial begin
    tick(12);
    rst <= 0;
    tick(2);
    chk(rail_en, 0);
    chk({gen_out_a_oe, gen_out_b_oe, gen_out_c_oe, gen_out_d_oe}, 4'hF);
    chk(rail_f_voltage_code, 7'h2C);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q, rows[i].x);
      if (!rows[i].w) chk(e, rows[i].e);
    end
    chk(step_down_pwm_force, 6'h15);
    for (int k = 0; k < 8; k++) begin
      {switch_group2_enable_in, switch_group1_enable_in,
        term_ldo_enable_in} <= 3'(k);
      tick(14);
      chk(rail_en[12:9], {k[2], k[1], k[1], k[0]});
      chk(rail_en[8:6], 3'h0);
    end
    seq(1, 1, 20);
    chk(rail_en[5:0], 6'h3F);
    chk({gen_out_a_oe, gen_out_b_oe}, 2'h0);
    sleep_select_in <= 1;
    tick(3);
    chk(sleep_active, 9'h020);
    chk(rail_f_voltage_code, 7'h26);
    sleep_select_in <= 0;
    seq(0, 1, 2);
    chk({gen_out_a_oe, gen_out_b_oe}, 2'h3);
    chk(rail_f_voltage_code, 7'h2D);
    wfall(0, t0);
    wfall(1, t1);
    chk(rail_en[2], 1);
    chk(t1 inside {[9:13]}, 1);
    seq(0, 0, 40);
    slow <= 1;
    seq(1, 1, 40);
    seq(0, 0, 0);
    wfall(0, t0);
    chk({rail_en[1], rail_en[5]}, 2'h0);
    apb(1, 8'h00, 32'h1F);
    tick(3);
    chk(rail_en[8:6], 3'h7);
    chk({gen_out_c_oe, gen_out_d_oe}, 2'h0);
    chk({gen_out_a_o, gen_out_b_o, gen_out_c_o, gen_out_d_o}, 4'h0);
    rail_fault <= 13'h0040;
    tick(3);
    chk(fault_shutdown, 0);
    rail_fault <= 13'h0200;
    tick(3);
    chk({fault_shutdown, rail_en}, 14'h2000);
    apb(0, 8'h10, 32'h0);
    chk(q, 32'h00010000);
    apb(0, 8'h14, 32'h0);
    chk(q, 32'h00000240);
    rail_fault <= 0;
    apb(1, 8'h14, 32'h1FFF);
    tick(3);
    chk(fault_shutdown, 0);
    apb(0, 8'h14, 32'h0);
    chk(q, 32'h00000000);
    rst <= 1;
    tick(2);
    chk({rail_en, gen_out_c_oe, gen_out_d_oe}, 15'h3);
    rst <= 0;
    tick(2);
    apb(0, 8'h00, 32'h0);
    chk(q, 0);
    finish_test;
  end
endmodule
